/* File: rtl/spp_consts.vh */
// Constants for the serial program port: commands, frame counts, core opcodes,
// special register addresses, control bits, timing and bus register map.
// Included by the bus slave and top design files; holds definitions only.
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH
`define SPP_CMD_CORE        4'h0
`define SPP_CMD_SHIFT_LATCH 4'h2
`define SPP_CMD_TBLRD_INC   4'h9
`define SPP_CMD_LOAD_INC2   4'hD
`define SPP_CMD_LOAD_PROG   4'hF
`define SPP_CMD_BITS        5'h04
`define SPP_OUT_FIRST       5'h0C
`define SPP_FRAME_LAST      5'h13
`define SPP_START_FALLS     5'h18
`define SPP_ROW_AW          6
`define SPP_ROW_LAST        6'h3F
`define SPP_OP_MOVLW        8'h0E
`define SPP_OP_MOVWF        8'h6E
`define SPP_OP_CLRF         8'h6A
`define SPP_OP_MOVF         8'h50
`define SPP_OP_BSF          8'b1000???0
`define SPP_OP_BCF          8'b1001???0
`define SPP_SFR_PTR_U       8'hF8
`define SPP_SFR_PTR_H       8'hF7
`define SPP_SFR_PTR_L       8'hF6
`define SPP_SFR_LATCH       8'hF5
`define SPP_SFR_EE_LO       8'hA9
`define SPP_SFR_EE_HI       8'hAA
`define SPP_SFR_EE_DATA     8'hA8
`define SPP_SFR_MCR         8'hA6
`define SPP_MCR_PGM_SEL     7
`define SPP_MCR_CFG_SEL     6
`define SPP_MCR_FREE        4
`define SPP_MCR_WRITE_ENABLE_BIT        2
`define SPP_MCR_GO          1
`define SPP_MCR_RD          0
`define SPP_MCR_MASK        8'hD6
`define SPP_SELF_TIME_US    5000
`define SPP_CLK_MHZ         100
`define SPP_SELF_CYCLES     20'h7A120
`define SPP_REG_PROTECT     8'h00
`define SPP_REG_STATUS      8'h04
`define SPP_REG_POINTER     8'h08
`define SPP_PROTECT_RESET   9'h000
`define SPP_PROTECT_EE      8
`endif

/* File: rtl/spp_sync.v */
// Two-stage synchroniser for levels from outside the clk domain.
// Assumes inputs change slowly against clk; only the second stage is used.
`timescale 1ns/1ns
module spp_sync
#(
	parameter WIDTH = 2
)
(
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= {WIDTH{1'b0}};
			q    <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // spp_sync

/* File: rtl/spp_ahb.v */
// AHB-Lite slave for the port's protection and status registers.
// Assumes single word transfers; zero wait states, always OKAY.
`timescale 1ns/1ns
`include "spp_consts.vh"
module spp_ahb
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [8:0]  protect,
	input  wire [8:0]  status,
	input  wire [21:0] pointer
);
	reg         wr_pend;
	reg  [7:0]  wr_addr;
	wire        take   = hsel && htrans[1] && hready;
	wire        in_map = (haddr[31:8] == 24'h000000);
	wire        fwd    = wr_pend && (wr_addr == `SPP_REG_PROTECT);
	reg  [31:0] rd_mux;

	// Forward a write still in its data phase so a back-to-back read sees it
	always @*
	begin
		rd_mux = 32'h00000000;
		if (in_map)
		begin
			case (haddr[7:0])
				`SPP_REG_PROTECT: rd_mux = {23'h000000, fwd ? hwdata[8:0] : protect};
				`SPP_REG_STATUS:  rd_mux = {23'h000000, status};
				`SPP_REG_POINTER: rd_mux = {10'h000, pointer};
				default:          rd_mux = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			protect   <= `SPP_PROTECT_RESET;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (fwd)
				protect <= hwdata[8:0];
			if (hready)
			begin
				wr_pend <= take && hwrite && in_map && (hsize == 3'h2);
				wr_addr <= haddr[7:0];
				if (take && !hwrite)
					hrdata <= rd_mux;
			end
		end
	end
endmodule // spp_ahb

/* File: rtl/spp_top.v */
// Serial program port of the device: frame engine, core instruction subset,
// code and data memories, self-timed erase and write sequencer.
// Assumes the programmer's clock half periods exceed two clk cycles.
// What this block does
// - Row erase of 64 bytes unless block protected
// - Rows sit on fixed boundaries from zero
// - Erase starts on fourth clock of second NOP
// - Any pointer byte selects its whole row
// - Control register polled through latch and 0010
// - Command 1101 loads two bytes, pointer plus two
// - Command 1111 loads last bytes, starts programming
// - EEPROM written bytewise through its address and data registers
// - EEPROM byte write stores the byte directly, no erase
// - Setting go bit starts the write sequence
// - EEPROM write starts at 24th falling clock
// - Command 1001 reads byte at table pointer
// - Command and data both least significant first
// - Data pin turns around after eighth operand clock
// - Table read increments pointer, full 22-bit space
// - Command 0000 executes payload as core instruction
`timescale 1ns/1ns
`include "spp_consts.vh"
module spp_top
#(
	parameter        CODE_AW     = 13,
	parameter        EE_AW       = 8,
	parameter        BLOCK_AW    = 12,
	parameter [19:0] SELF_CYCLES = `SPP_SELF_CYCLES
)
(
	input  wire        clk,
	input  wire        arst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        serial_prog_clock,
	input  wire        serial_prog_data_in,
	output reg         serial_prog_data_out,
	output reg         serial_prog_data_oe_n
);
	localparam [2:0] OP_IDLE  = 3'd0;
	localparam [2:0] OP_WAIT  = 3'd1;
	localparam [2:0] OP_ERASE = 3'd2;
	localparam [2:0] OP_EEWR  = 3'd3;
	localparam [2:0] OP_TIMER = 3'd4;
	localparam [2:0] OP_PROG  = 3'd5;

	reg  [1:0]  rst_sync;
	wire        rst_n = rst_sync[1];
	wire [1:0]  pin_s;
	wire        pgc_s = pin_s[1];
	wire        pgd_s = pin_s[0];
	wire [8:0]  protect;

	reg  [7:0]  code_mem [0:(1<<CODE_AW)-1];
	reg  [7:0]  ee_mem   [0:(1<<EE_AW)-1];
	reg  [7:0]  wbuf     [0:(1<<`SPP_ROW_AW)-1];

	reg         pgc_q;
	reg  [3:0]  cmd;
	reg  [15:0] shreg;
	reg  [4:0]  cnt;
	reg  [7:0]  out_byte;
	reg  [7:0]  w;
	reg  [21:0] ptr;
	reg  [7:0]  tlat;
	reg  [7:0]  ee_lo;
	reg  [7:0]  ee_hi;
	reg  [7:0]  ee_data;
	reg  [7:0]  mcr;
	reg  [2:0]  op_state;
	reg  [4:0]  falls;
	reg  [5:0]  op_idx;
	reg  [19:0] timer;
	reg  [CODE_AW-`SPP_ROW_AW-1:0] row_base;
	// Done is seen in the cycle the sequencer goes idle, so go never outlives busy
	wire        wr_done   = (op_state == OP_TIMER) && (timer == SELF_CYCLES - 20'h00001);
	reg  [7:0]  reg_rd;
	reg         sfr_we;
	reg  [7:0]  sfr_d;

	wire        pgc_rise  = pgc_s && !pgc_q;
	wire        pgc_fall  = !pgc_s && pgc_q;
	wire [15:0] word      = {pgd_s, shreg[15:1]};
	wire [7:0]  lit       = word[7:0];
	wire        frame_end = pgc_fall && (cnt == `SPP_FRAME_LAST);
	wire        is_read   = (cmd == `SPP_CMD_TBLRD_INC) || (cmd == `SPP_CMD_SHIFT_LATCH);
	wire        exec      = frame_end && (cmd == `SPP_CMD_CORE);
	wire        load_now  = frame_end &&
		((cmd == `SPP_CMD_LOAD_INC2) || (cmd == `SPP_CMD_LOAD_PROG));
	wire        in_code   = (ptr[21:CODE_AW] == {(22-CODE_AW){1'b0}});
	wire [7:0]  rd_byte   = in_code ? code_mem[ptr[CODE_AW-1:0]] : 8'hFF;
	wire [5:0]  ptr_nb    = ptr[5:0] + 6'h01;
	wire [15:0] ee_addr   = {ee_hi, ee_lo};
	wire [7:0]  bit_mask  = 8'h01 << word[11:9];
	wire        mcr_wr    = sfr_we && (lit == `SPP_SFR_MCR);
	wire        wr_start  = mcr_wr && sfr_d[`SPP_MCR_GO] && !mcr[`SPP_MCR_GO] &&
		mcr[`SPP_MCR_WRITE_ENABLE_BIT];
	wire        busy      = (op_state != OP_IDLE);
	wire        cm_we     = (op_state == OP_ERASE) || (op_state == OP_PROG);
	wire [CODE_AW-1:0] cm_addr = {row_base, op_idx};
	wire [7:0]  cm_d      = (op_state == OP_PROG) ? wbuf[op_idx] : 8'hFF;
	wire        blocked   = !in_code || blk_locked(ptr, protect);
	wire        code_erase = mcr[`SPP_MCR_PGM_SEL] && !mcr[`SPP_MCR_CFG_SEL] &&
		mcr[`SPP_MCR_FREE] && !blocked;
	wire        ee_write  = !mcr[`SPP_MCR_PGM_SEL] && !mcr[`SPP_MCR_CFG_SEL] &&
		!protect[`SPP_PROTECT_EE];
	wire        prog_start = load_now && (cmd == `SPP_CMD_LOAD_PROG) &&
		mcr[`SPP_MCR_WRITE_ENABLE_BIT] && mcr[`SPP_MCR_PGM_SEL] && !mcr[`SPP_MCR_CFG_SEL] && !blocked;

	// Code or write protection of the block that holds an address
	function blk_locked;
		input [21:0] a;
		input [8:0]  p;
		reg   [1:0]  b;
		begin
			b = a[BLOCK_AW+1:BLOCK_AW];
			blk_locked = p[{1'b0, b}] | p[{1'b1, b}];
		end
	endfunction

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	spp_sync #(.WIDTH(2)) u_sync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({serial_prog_clock, serial_prog_data_in}),
		.q     (pin_s)
	);

	spp_ahb u_ahb
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.protect   (protect),
		.status    ({busy, mcr}),
		.pointer   (ptr)
	);

	always @*
	begin
		case (lit)
			`SPP_SFR_PTR_U:   reg_rd = {2'b00, ptr[21:16]};
			`SPP_SFR_PTR_H:   reg_rd = ptr[15:8];
			`SPP_SFR_PTR_L:   reg_rd = ptr[7:0];
			`SPP_SFR_LATCH:   reg_rd = tlat;
			`SPP_SFR_EE_LO:   reg_rd = ee_lo;
			`SPP_SFR_EE_HI:   reg_rd = ee_hi;
			`SPP_SFR_EE_DATA: reg_rd = ee_data;
			`SPP_SFR_MCR:     reg_rd = mcr;
			default:          reg_rd = 8'h00;
		endcase
	end

	// Only the instructions a programmer needs to reach the port's registers
	always @*
	begin
		sfr_we = 1'b0;
		sfr_d  = w;
		if (exec)
		begin
			casez (word[15:8])
				`SPP_OP_MOVWF: sfr_we = 1'b1;
				`SPP_OP_CLRF:
				begin
					sfr_we = 1'b1;
					sfr_d  = 8'h00;
				end
				`SPP_OP_BSF:
				begin
					sfr_we = 1'b1;
					sfr_d  = reg_rd | bit_mask;
				end
				`SPP_OP_BCF:
				begin
					sfr_we = 1'b1;
					sfr_d  = reg_rd & ~bit_mask;
				end
				default: sfr_we = 1'b0;
			endcase
		end
	end

	// Frame engine: 4 command bits then 16 payload bits, sampled on falling clock
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pgc_q                 <= 1'b0;
			cmd                   <= 4'h0;
			shreg                 <= 16'h0000;
			cnt                   <= 5'h00;
			out_byte              <= 8'h00;
			w                     <= 8'h00;
			ptr                   <= 22'h000000;
			tlat                  <= 8'h00;
			ee_lo                 <= 8'h00;
			ee_hi                 <= 8'h00;
			ee_data               <= 8'h00;
			mcr                   <= 8'h00;
			serial_prog_data_out  <= 1'b0;
			serial_prog_data_oe_n <= 1'b1;
		end
		else
		begin
			pgc_q <= pgc_s;
			if (pgc_fall)
			begin
				if (cnt < `SPP_CMD_BITS)
					cmd[cnt[1:0]] <= pgd_s;
				else
					shreg <= word;
				cnt <= frame_end ? 5'h00 : cnt + 5'h01;
			end
			if (pgc_fall && (cnt == `SPP_OUT_FIRST - 5'h01) && is_read)
			begin
				if (cmd == `SPP_CMD_TBLRD_INC)
				begin
					out_byte <= rd_byte;
					tlat     <= rd_byte;
					ptr      <= ptr + 22'h000001;
				end
				else
					out_byte <= tlat;
			end
			// Pin turns to output only once the host has started the output clocks
			if (pgc_rise && (cnt >= `SPP_OUT_FIRST) && is_read)
			begin
				serial_prog_data_out  <= out_byte[0];
				out_byte              <= {1'b0, out_byte[7:1]};
				serial_prog_data_oe_n <= 1'b0;
			end
			if (frame_end)
				serial_prog_data_oe_n <= 1'b1;
			if (load_now && (cmd == `SPP_CMD_LOAD_INC2))
				ptr <= ptr + 22'h000002;
			if (exec && (word[15:8] == `SPP_OP_MOVLW))
				w <= lit;
			if (exec && (word[15:8] == `SPP_OP_MOVF))
				w <= reg_rd;
			if (sfr_we)
			begin
				case (lit)
					`SPP_SFR_PTR_U:   ptr[21:16] <= sfr_d[5:0];
					`SPP_SFR_PTR_H:   ptr[15:8] <= sfr_d;
					`SPP_SFR_PTR_L:   ptr[7:0] <= sfr_d;
					`SPP_SFR_LATCH:   tlat <= sfr_d;
					`SPP_SFR_EE_LO:   ee_lo <= sfr_d;
					`SPP_SFR_EE_HI:   ee_hi <= sfr_d;
					`SPP_SFR_EE_DATA: ee_data <= sfr_d;
					default:          tlat <= tlat;
				endcase
			end
			// Go bit is set only by software with write enable, cleared only by hardware
			if (mcr_wr)
			begin
				mcr <= sfr_d & `SPP_MCR_MASK;
				mcr[`SPP_MCR_GO] <= (mcr[`SPP_MCR_GO] && !wr_done) || wr_start;
				if (sfr_d[`SPP_MCR_RD] && !sfr_d[`SPP_MCR_PGM_SEL] && !sfr_d[`SPP_MCR_CFG_SEL])
					ee_data <= ee_mem[ee_addr[EE_AW-1:0]];
			end
			else if (wr_done)
				mcr[`SPP_MCR_GO] <= 1'b0;
		end
	end

	// Sequencer for self-timed erase, EEPROM write and buffer programming
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_state <= OP_IDLE;
			falls    <= 5'h00;
			op_idx   <= 6'h00;
			timer    <= 20'h00000;
			row_base <= {(CODE_AW-`SPP_ROW_AW){1'b0}};
		end
		else
		begin
			case (op_state)
				OP_IDLE:
				begin
					if (wr_start)
					begin
						op_state <= OP_WAIT;
						falls    <= 5'h00;
					end
					else if (prog_start)
					begin
						op_state <= OP_PROG;
						op_idx   <= 6'h00;
						row_base <= ptr[CODE_AW-1:`SPP_ROW_AW];
					end
				end
				OP_WAIT:
				begin
					if (pgc_fall)
					begin
						falls <= falls + 5'h01;
						if (falls == `SPP_START_FALLS - 5'h01)
						begin
							op_idx   <= 6'h00;
							timer    <= 20'h00000;
							row_base <= ptr[CODE_AW-1:`SPP_ROW_AW];
							if (code_erase)
								op_state <= OP_ERASE;
							else if (ee_write)
								op_state <= OP_EEWR;
							else
								op_state <= OP_TIMER;
						end
					end
				end
				OP_ERASE:
				begin
					op_idx <= op_idx + 6'h01;
					if (op_idx == `SPP_ROW_LAST)
						op_state <= OP_TIMER;
				end
				OP_EEWR: op_state <= OP_TIMER;
				OP_TIMER:
				begin
					timer <= timer + 20'h00001;
					if (timer == SELF_CYCLES - 20'h00001)
					begin
						op_state <= OP_IDLE;
					end
				end
				OP_PROG:
				begin
					op_idx <= op_idx + 6'h01;
					if (op_idx == `SPP_ROW_LAST)
						op_state <= OP_IDLE;
				end
				default: op_state <= OP_IDLE;
			endcase
		end
	end

	// Memory arrays carry no reset; erase, writes and loads define their contents
	always @(posedge clk)
	begin
		if (cm_we)
			code_mem[cm_addr] <= cm_d;
		if (op_state == OP_EEWR)
			ee_mem[ee_addr[EE_AW-1:0]] <= ee_data;
		if (op_state == OP_PROG)
			wbuf[op_idx] <= 8'hFF;
		if (load_now)
		begin
			wbuf[ptr[5:0]] <= word[7:0];
			wbuf[ptr_nb]   <= word[15:8];
		end
	end
endmodule // spp_top

/* File: verif/spp_prog_model.sv */
// Programmer model: drives the serial clock and data pin, reads the pin back.
// Assumes one task call at a time; the clock stands low between frames.
`timescale 1ns/1ns
module spp_prog_model
(
	input  wire logic serial_prog_data_out,
	input  wire logic serial_prog_data_oe_n,
	output logic      serial_prog_clock,
	output wire logic serial_prog_data_in
);
	logic d  = 1'b0;
	logic en = 1'b1;
	// No pull on the pin: once released it shows the inverse of the last bit
	assign serial_prog_data_in = !serial_prog_data_oe_n ? serial_prog_data_out : (en ? d : ~d);
	initial serial_prog_clock = 1'b0;
	task automatic tick(input logic v);
		serial_prog_clock = 1'b1;
		d = v;
		#80;
		serial_prog_clock = 1'b0;
		#80;
	endtask
	task automatic frame(input logic [3:0] c, input logic [15:0] p, output logic [7:0] r);
		r = 8'h00;
		// Keep edges 3 ns off the clk grid so sampling never races
		#((13 - ($time % 10)) % 10);
		for (int i = 0; i < 4; i++)
			tick(c[i]);
		if (c == 4'h9 || c == 4'h2)
		begin
			for (int i = 0; i < 8; i++)
				tick(1'b0);
			#40;
			en = 1'b0;
			for (int i = 0; i < 8; i++)
			begin
				serial_prog_clock = 1'b1;
				#80;
				r[i] = serial_prog_data_in;
				serial_prog_clock = 1'b0;
				#80;
			end
			en = 1'b1;
		end
		else
			for (int i = 0; i < 16; i++)
				tick(p[i]);
	endtask
	task automatic pause(input int ns);
		#(ns);
	endtask
endmodule // spp_prog_model

/* File: verif/spp_top_properties.sv */
// Checker on the top ports: bus answers and the data pin's read window.
// Assumes hready is tied to hreadyout; bound at the foot of this file.
`timescale 1ns/1ns
module spp_top_props
(
	input wire        clk,
	input wire        arst_n,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        serial_prog_clock,
	input wire        serial_prog_data_in,
	input wire        serial_prog_data_out,
	input wire        serial_prog_data_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Shadow of protection writes, so readback is judged independently
	reg [8:0] shadow;
	reg       wr_q;
	reg       oe_q;
	reg [2:0] sck_q;
	reg [3:0] rises;
	always @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			shadow <= 9'h000;
			wr_q   <= 1'b0;
			oe_q   <= 1'b1;
			sck_q  <= 3'h0;
			rises  <= 4'h0;
		end
		else
		begin
			wr_q  <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0 && hsize == 3'h2;
			oe_q  <= serial_prog_data_oe_n;
			sck_q <= {sck_q[1:0], serial_prog_clock};
			if (wr_q)
				shadow <= hwdata[8:0];
			if (oe_q && !serial_prog_data_oe_n)
				rises <= 4'h0;
			else if (sck_q[1] && !sck_q[2] && !serial_prog_data_oe_n)
				rises <= rises + 4'h1;
		end
	sequence s_rd(logic [31:0] a);
		hsel && htrans[1] && hready && !hwrite && haddr == a;
	endsequence
	sequence s_hole;
		hsel && htrans[1] && hready && !hwrite && haddr > 32'h8;
	endsequence
	property p_okay;
		hreadyout && !hresp;
	endproperty
	property p_protect;
		s_rd(32'h0) |=> hrdata == {23'h0, shadow};
	endproperty
	property p_pointer;
		s_rd(32'h8) |=> hrdata[31:22] == 10'h0;
	endproperty
	property p_status;
		s_rd(32'h4) |=> (hrdata & 32'hFFFFFE29) == 32'h0;
	endproperty
	property p_go_busy;
		s_rd(32'h4) |=> !hrdata[1] || hrdata[8];
	endproperty
	property p_hole;
		s_hole |=> hrdata == 32'h0;
	endproperty
	property p_drive_rise;
		$fell(serial_prog_data_oe_n) |-> serial_prog_clock;
	endproperty
	property p_release_fall;
		$rose(serial_prog_data_oe_n) |-> !serial_prog_clock;
	endproperty
	property p_bit_rise;
		!serial_prog_data_oe_n && $changed(serial_prog_data_out) |-> serial_prog_clock;
	endproperty
	property p_eight;
		$rose(serial_prog_data_oe_n) |-> rises == 4'h7;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	a_protect: assert property (p_protect) else $error("protect readback wrong");
	a_pointer: assert property (p_pointer) else $error("pointer above 22 bits");
	a_status: assert property (p_status) else $error("status spare bits set");
	a_go_busy: assert property (p_go_busy) else $error("go set while idle");
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	a_drive_rise: assert property (p_drive_rise) else $error("drive not on rise");
	a_release_fall: assert property (p_release_fall) else $error("release not on fall");
	a_bit_rise: assert property (p_bit_rise) else $error("bit moved off rise");
	a_eight: assert property (p_eight) else $error("read window not 8 bits");
endmodule // spp_top_props
bind spp_top spp_top_props u_props
(
	.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .serial_prog_clock(serial_prog_clock),
	.serial_prog_data_in(serial_prog_data_in), .serial_prog_data_out(serial_prog_data_out),
	.serial_prog_data_oe_n(serial_prog_data_oe_n)
);

/* File: verif/test_spp_top.sv */
// Bench: bus registers, row program and erase, table reads, EEPROM writes.
// Assumes the programmer model owns the serial pins; self-timing cut to 20 clk.
`timescale 1ns/1ns
`define CHK(n, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
		end \
	end
module test_spp_top;
	logic        clk, arst_n, hsel, hwrite, hreadyout, hresp;
	logic        sck, sdi, sdo, soe_n;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0]  b, x, ea;
	logic [7:0]  row [64];
	logic [21:0] base;
	logic [8:0]  v;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	spp_top #(.SELF_CYCLES(20'd20)) uut
	(
		.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_prog_clock(sck),
		.serial_prog_data_in(sdi), .serial_prog_data_out(sdo), .serial_prog_data_oe_n(soe_n)
	);
	spp_prog_model u_prog
	(
		.serial_prog_data_out(sdo), .serial_prog_data_oe_n(soe_n),
		.serial_prog_clock(sck), .serial_prog_data_in(sdi)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic core(input logic [7:0] op, input logic [7:0] arg);
		u_prog.frame(4'h0, {op, arg}, b);
	endtask
	task automatic setp(input logic [21:0] a);
		core(8'h0E, {2'b00, a[21:16]});
		core(8'h6E, 8'hF8);
		core(8'h0E, a[15:8]);
		core(8'h6E, 8'hF7);
		core(8'h0E, a[7:0]);
		core(8'h6E, 8'hF6);
	endtask
	task automatic go;
		core(8'h82, 8'hA6);
		ahb(1'b0, 32'h4, 32'h0);
		core(8'h00, 8'h00);
		core(8'h00, 8'h00);
		core(8'h50, 8'hA6);
		core(8'h6E, 8'hF5);
		core(8'h00, 8'h00);
		u_prog.frame(4'h2, 16'h0000, b);
	endtask
	task automatic rdchk(input logic [21:0] a, input int n, input logic ff);
		setp(a);
		for (int i = 0; i < n; i++)
		begin
			u_prog.frame(4'h9, 16'h0000, b);
			`CHK("table read", ff ? 8'hFF : row[a[5:0] + i], b)
		end
	endtask
	task automatic prog;
		setp(base);
		for (int i = 0; i < 62; i += 2)
			u_prog.frame(4'hD, {row[i + 1], row[i]}, b);
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("pointer after loads", {10'h0, base + 22'd62}, rd)
		u_prog.frame(4'hF, {row[63], row[62]}, b);
		core(8'h00, 8'h00);
		u_prog.pause(2000);
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("pointer after start", {10'h0, base + 22'd62}, rd)
	endtask
	task automatic eew(input logic [7:0] d);
		core(8'h0E, ea);
		core(8'h6E, 8'hA9);
		core(8'h6A, 8'hAA);
		core(8'h0E, d);
		core(8'h6E, 8'hA8);
		core(8'h84, 8'hA6);
		go();
		`CHK("eeprom go", 1'b0, b[1])
	endtask
	initial
	begin
		arst_n = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		void'($urandom(32'h77772529));
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		ahb(1'b0, 32'h0, 32'h0);
		`CHK("protect reset", 32'h0, rd)
		v = $urandom;
		ahb(1'b1, 32'h0, {23'h0, v});
		hsize <= 3'h0;
		ahb(1'b1, 32'h0, 32'h0);
		hsize <= 3'h2;
		ahb(1'b0, 32'h0, 32'h0);
		`CHK("protect", {23'h0, v}, rd)
		ahb(1'b1, 32'h0, 32'h0);
		ahb(1'b0, 32'h0C, 32'h0);
		`CHK("hole", 32'h0, rd)
		$display("test bus done");
		core(8'h8E, 8'hA6);
		core(8'h9C, 8'hA6);
		core(8'h84, 8'hA6);
		// Leave room for the next row so the row-by-row erase stays in code space
		base = {9'h0, 7'($urandom_range(126, 1)), 6'h00};
		foreach (row[i])
			row[i] = $urandom;
		prog();
		rdchk(base, 64, 1'b0);
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("pointer after reads", {10'h0, base + 22'd64}, rd)
		$display("test program done");
		ahb(1'b1, 32'h0, 32'h10 << base[13:12]);
		setp(base + 22'd5);
		core(8'h88, 8'hA6);
		go();
		ahb(1'b1, 32'h0, 32'h0);
		u_prog.frame(4'h9, 16'h0000, b);
		rdchk(base, 2, 1'b0);
		core(8'h94, 8'hA6);
		core(8'h82, 8'hA6);
		ahb(1'b0, 32'h4, 32'h0);
		`CHK("go without enable", 1'b0, rd[1])
		core(8'h84, 8'hA6);
		setp(base + 22'($urandom_range(63, 0)));
		core(8'h88, 8'hA6);
		go();
		`CHK("busy after go", 2'b11, {rd[8], rd[1]})
		`CHK("go cleared", 2'b10, b[2:1])
		setp(base + 22'd64);
		go();
		`CHK("next row go cleared", 2'b10, b[2:1])
		rdchk(base, 8, 1'b1);
		rdchk(base + 22'd56, 16, 1'b1);
		rdchk(22'h3FFFFF, 1, 1'b1);
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("pointer wrap", 32'h0, rd)
		core(8'h98, 8'hA6);
		foreach (row[i])
			row[i] ^= 8'($urandom);
		prog();
		rdchk(base + 22'd60, 4, 1'b0);
		$display("test erase done");
		core(8'h9E, 8'hA6);
		core(8'h9C, 8'hA6);
		ea = $urandom;
		x = $urandom;
		eew(x);
		eew(~x);
		core(8'h0E, ea);
		core(8'h6E, 8'hA9);
		core(8'h80, 8'hA6);
		core(8'h50, 8'hA8);
		core(8'h6E, 8'hF5);
		u_prog.frame(4'h2, 16'h0000, b);
		`CHK("eeprom byte", ~x, b)
		$display("test eeprom done");
		print_verdict();
	end
endmodule // test_spp_top
